//--- rba_arbiter.sv
// Device end: refresh control and bus arbitration.
`timescale 1ns/1ns
module rba_arbiter import rba_pkg::*; #(
  parameter int unsigned PERIOD = RBA_REFRESH_CYCLES,
  parameter int unsigned RAS_CYCLES = RBA_RAS_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  rba_link_if.ctrl link,
  input wire logic hiddenMode,
  input wire logic cpuDramReq,
  input wire logic cpuBusReq,
  output logic cpuWait,
  output logic dramCas_n,
  output logic dramRas_n,
  output rba_owner_t owner,
  output logic refreshBusy
);
  rba_arb_t state;
  logic tick;
  logic refreshPending;
  logic refreshFirst;
  logic [$clog2(RAS_CYCLES+1)-1:0] phase;
  logic [RBA_ROW_WIDTH-1:0] row;
  logic hiddenDram;
  logic hiddenBus;
  logic phaseDone;
  logic busRefresh;
  logic dramRefresh;
  logic startHidden;
  logic masterTick;
  logic grantSettled;

  // Both refresh states run the phase counter and advance the row.
  function automatic logic isRefreshing(input rba_arb_t st);
    return st == RBA_ARB_REFRESH || st == RBA_ARB_HIDDEN;
  endfunction : isRefreshing

  // The divider runs free, so ticks keep their pace however busy the bus is.
  rba_rate_gen #(.PERIOD(PERIOD)) u_rba_rate_gen (
    .mclk(mclk),
    .srst(srst),
    .refresh_rate_tick(tick)
  );

  assign phaseDone = phase == $bits(phase)'(RAS_CYCLES);
  // Shared decodes of the refresh that is driving each resource.
  assign startHidden = state == RBA_ARB_IDLE && hiddenMode && (refreshPending || tick);
  assign busRefresh = state == RBA_ARB_REFRESH || hiddenBus;
  assign dramRefresh = state == RBA_ARB_REFRESH || hiddenDram;
  assign masterTick = tick && state == RBA_ARB_GRANT && owner == RBA_OWNER_MASTER;

  // A request that arrives while a DMA owns the grant waits here, so it is not lost.
  // A master cannot be preempted, so a tick in its grant is left to the master itself.
  always_ff @(posedge mclk) begin
    if (srst) begin
      refreshPending <= 1'b0;
    end else if (startHidden) begin
      refreshPending <= 1'b0; // see R2
    end else if (masterTick) begin
      refreshPending <= refreshPending; // see R9
    end else if (tick) begin
      refreshPending <= 1'b1; // see R16
    end else if (state == RBA_ARB_REFRESH) begin
      refreshPending <= 1'b0;
    end
  end

  // Ordering latch: set when refresh was pending before the hold request rose.
  always_ff @(posedge mclk) begin
    if (srst) begin
      refreshFirst <= 1'b0;
    end else if (state == RBA_ARB_IDLE) begin
      refreshFirst <= refreshPending || (tick && !link.hold_request_in); // see R15
    end else if (state == RBA_ARB_REFRESH && phaseDone) begin
      refreshFirst <= 1'b0;
    end
  end

  // Hidden refresh never raises HOLD; every other owner goes through the hold handshake.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= RBA_ARB_IDLE; // see R1
    end else begin
      unique case (state)
        RBA_ARB_IDLE: begin
          if (startHidden) begin
            state <= RBA_ARB_HIDDEN; // see R2
          end else if (refreshPending || tick || link.hold_request_in) begin
            state <= RBA_ARB_HOLD; // see R11
          end
        end
        RBA_ARB_HOLD: begin
          if (link.holdAck) begin
            state <= refreshFirst ? RBA_ARB_REFRESH : RBA_ARB_GRANT; // see R13
          end
        end
        RBA_ARB_REFRESH: begin
          if (phaseDone) begin
            state <= link.hold_request_in ? RBA_ARB_GRANT : RBA_ARB_IDLE; // see R17
          end
        end
        RBA_ARB_GRANT: begin
          if (!link.hold_request_in) begin
            state <= refreshPending ? RBA_ARB_REFRESH : RBA_ARB_IDLE; // see R16 R19
          end
        end
        RBA_ARB_HIDDEN: begin
          if (phaseDone) begin
            state <= RBA_ARB_IDLE;
          end
        end
        default: state <= RBA_ARB_IDLE;
      endcase
    end
  end

  // Hidden mode runs the DRAM and bus refresh as two separate resources.
  // They end together here, but each one frees only its own resource for the processor.
  always_ff @(posedge mclk) begin
    if (srst) begin
      hiddenDram <= 1'b0;
      hiddenBus <= 1'b0;
    end else if (startHidden) begin
      hiddenDram <= 1'b1; // see R4
      hiddenBus <= 1'b1; // see R5
    end else if (phaseDone) begin
      hiddenDram <= 1'b0;
      hiddenBus <= 1'b0;
    end
  end

  // The phase counter parks on its last value until the refresh state is left.
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase <= '0;
    end else if (isRefreshing(state)) begin
      phase <= phaseDone ? phase : phase + 1'b1;
    end else begin
      phase <= '0;
    end
  end

  // The row advances once per refresh cycle, in either mode.
  always_ff @(posedge mclk) begin
    if (srst) begin
      row <= RBA_ROW_RESET;
    end else if (phaseDone && isRefreshing(state)) begin
      row <= row + RBA_ROW_STEP;
    end
  end

  // The requester raises its address enables one cycle after the grant, so that first
  // cycle is not decoded; read too early, every owner would look like a master.
  always_ff @(posedge mclk) begin
    if (srst) begin
      grantSettled <= 1'b0;
    end else begin
      grantSettled <= state == RBA_ARB_GRANT;
    end
  end

  // Owner is decoded only while the grant stands, and reads none otherwise.
  always_ff @(posedge mclk) begin
    if (srst) begin
      owner <= RBA_OWNER_NONE;
    end else if (state == RBA_ARB_GRANT && grantSettled) begin
      if (!link.dma_byte_addr_enable_n) begin
        owner <= RBA_OWNER_DMA8; // see R18
      end else if (!link.dma_word_addr_enable_n) begin
        owner <= RBA_OWNER_DMA16;
      end else begin
        owner <= RBA_OWNER_MASTER;
      end
    end else begin
      owner <= RBA_OWNER_NONE;
    end
  end

  // CAS leads RAS by one cycle so the DRAM counts its own refresh row.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dramCas_n <= 1'b1;
      dramRas_n <= 1'b1;
    end else begin
      dramCas_n <= !(dramRefresh && !phaseDone); // see R7
      dramRas_n <= !(dramRefresh && phase != '0 && !phaseDone);
    end
  end

  // A bus refresh drives the strobe, a memory read and the row together.
  always_comb begin
    link.hold = state == RBA_ARB_HOLD || state == RBA_ARB_REFRESH
        || state == RBA_ARB_GRANT; // see R11 R14
    link.bus_grant_out = state == RBA_ARB_GRANT; // see R13
    link.refreshStrobe_n = !busRefresh; // see R6
    link.memRead_n = !busRefresh;
    link.refreshRowOe = busRefresh;
  end

  // Wait states stretch a processor access only while its own resource is refreshing.
  always_comb begin
    cpuWait = (cpuDramReq && hiddenDram) || (cpuBusReq && hiddenBus); // see R3
    refreshBusy = isRefreshing(state);
  end

  assign link.refreshRow = row;
endmodule : rba_arbiter

//--- rba_pkg.sv
// Shared constants and types for the refresh and bus arbitration link.
// Functional notes
// R1 - Normal refresh after reset, processor held off.
// R2 - Hidden refresh never requests the processor bus.
// R3 - Wait states while hidden refresh holds resource.
// R4 - Hidden mode: DRAM and bus refresh separate.
// R5 - Bus side arbitrates processor, DMA, bus refresh.
// R6 - Bus refresh drives refresh strobe, read, row.
// R7 - Local DRAM refresh uses CAS-before-RAS.
// R8 - Rate generator ticks every 15 us.
// R9 - Never preempt an owning bus master.
// R10 - Long-holding masters refresh by themselves.
// R11 - HOLD for DMA, masters, normal refresh.
// R12 - Processor finishes cycle, then acknowledges hold.
// R13 - After acknowledge: refresh strobe or grant.
// R14 - HOLD stays negated during hidden refresh.
// R15 - Refresh versus hold request: first come first served.
// R16 - Refresh queued behind hold served right after.
// R17 - Hold request stays until earlier refresh served.
// R18 - Shared request; address enables tell DMA from master.
// R19 - Release with nothing pending drops grant and HOLD.
package rba_pkg;
  localparam int unsigned RBA_CLK_MHZ = 125;
  localparam int unsigned RBA_REFRESH_PERIOD_NS = 15000;
  localparam int unsigned RBA_REFRESH_CYCLES = RBA_REFRESH_PERIOD_NS * RBA_CLK_MHZ / 1000;
  localparam int unsigned RBA_RAS_HOLD_CYCLES = 4;
  localparam int unsigned RBA_ISA_REFRESH_CYCLES = 6;
  localparam int unsigned RBA_ROW_WIDTH = 8;
  localparam logic [7:0] RBA_ROW_RESET = 8'h00;
  localparam logic [7:0] RBA_ROW_STEP = 8'h01;

  typedef enum logic [2:0] {
    RBA_ARB_IDLE = 3'b000,
    RBA_ARB_HOLD = 3'b001,
    RBA_ARB_REFRESH = 3'b010,
    RBA_ARB_GRANT = 3'b011,
    RBA_ARB_HIDDEN = 3'b100
  } rba_arb_t;

  typedef enum logic [1:0] {
    RBA_OWNER_NONE = 2'b00,
    RBA_OWNER_DMA8 = 2'b01,
    RBA_OWNER_DMA16 = 2'b10,
    RBA_OWNER_MASTER = 2'b11
  } rba_owner_t;
endpackage : rba_pkg

//--- rba_link_if.sv
// Link between the arbitration unit and its bus partners.
`timescale 1ns/1ns
interface rba_link_if;
  logic hold;
  logic holdAck;
  logic hold_request_in;
  logic bus_grant_out;
  logic dma_byte_addr_enable_n;
  logic dma_word_addr_enable_n;
  logic refreshStrobe_n;
  logic memRead_n;
  logic [7:0] refreshRow;
  logic refreshRowOe;

  modport ctrl (
    output hold,
    input holdAck,
    input hold_request_in,
    output bus_grant_out,
    input dma_byte_addr_enable_n,
    input dma_word_addr_enable_n,
    output refreshStrobe_n,
    output memRead_n,
    output refreshRow,
    output refreshRowOe
  );

  modport partner (
    input hold,
    output holdAck,
    output hold_request_in,
    input bus_grant_out,
    output dma_byte_addr_enable_n,
    output dma_word_addr_enable_n,
    input refreshStrobe_n,
    input memRead_n,
    input refreshRow,
    input refreshRowOe
  );
endinterface : rba_link_if

//--- rba_rate_gen.sv
// Periodic refresh rate generator producing a one-cycle tick.
`timescale 1ns/1ns
module rba_rate_gen import rba_pkg::*; #(
  parameter int unsigned PERIOD = RBA_REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  output logic refresh_rate_tick
);
  logic [$clog2(PERIOD)-1:0] count;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= '0;
      refresh_rate_tick <= 1'b0;
    end else if (count == $clog2(PERIOD)'(PERIOD - 1)) begin
      count <= '0;
      refresh_rate_tick <= 1'b1; // see R8
    end else begin
      count <= count + 1'b1;
      refresh_rate_tick <= 1'b0;
    end
  end
endmodule : rba_rate_gen

//--- rba_partner.sv
// Far end: processor hold handshake plus the shared DMA or master requester.
`timescale 1ns/1ns
module rba_partner import rba_pkg::*; #(
  parameter int unsigned SELF_REFRESH = RBA_ISA_REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  rba_link_if.partner link,
  input wire logic cpuBusy,
  input wire logic userReq,
  input wire logic userDma8,
  input wire logic userDma16,
  output logic granted,
  output logic needSelfRefresh
);
  logic [$clog2(SELF_REFRESH+1)-1:0] ownCount;

  always_ff @(posedge mclk) begin
    if (srst) begin
      link.holdAck <= 1'b0;
    end else begin
      link.holdAck <= link.hold && (link.holdAck || !cpuBusy); // see R12
    end
  end

  // The request is held until the grant has been seen, even behind a refresh.
  always_ff @(posedge mclk) begin
    if (srst) begin
      link.hold_request_in <= 1'b0;
    end else begin
      link.hold_request_in <= userReq || (link.hold_request_in && !link.bus_grant_out); // see R17
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      link.dma_byte_addr_enable_n <= 1'b1;
      link.dma_word_addr_enable_n <= 1'b1;
    end else begin
      link.dma_byte_addr_enable_n <= !(link.bus_grant_out && userDma8); // see R18
      link.dma_word_addr_enable_n <= !(link.bus_grant_out && userDma16 && !userDma8);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !link.bus_grant_out || userDma8 || userDma16) begin
      ownCount <= '0;
    end else if (ownCount != $bits(ownCount)'(SELF_REFRESH)) begin
      ownCount <= ownCount + 1'b1;
    end else begin
      ownCount <= '0;
    end
  end

  assign needSelfRefresh = ownCount == $bits(ownCount)'(SELF_REFRESH); // see R10
  assign granted = link.bus_grant_out;
endmodule : rba_partner

//--- rba_link_sva.sv
// Checker on the signals of the arbitration link.
`timescale 1ns/1ns
module rba_link_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hold,
  input wire logic holdAck,
  input wire logic hold_request_in,
  input wire logic bus_grant_out,
  input wire logic refreshStrobe_n,
  input wire logic memRead_n,
  input wire logic [7:0] refreshRow,
  input wire logic refreshRowOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [7:0] expRow;
  // The row is compared at refresh start, so the step timing inside a cycle is free.
  always_ff @(posedge mclk) begin
    if (srst) begin
      expRow <= 8'h00;
    end else if ($fell(refreshStrobe_n)) begin
      expRow <= expRow + 8'h01;
    end
  end
  sequence s_refresh; !refreshStrobe_n [*5] ##1 refreshStrobe_n; endsequence
  property p_len; $fell(refreshStrobe_n) |-> s_refresh; endproperty
  property p_cmd; !refreshStrobe_n |-> !memRead_n && refreshRowOe; endproperty
  property p_row; $fell(refreshStrobe_n) |-> refreshRow == expRow; endproperty
  property p_grantAck; bus_grant_out |-> hold && holdAck; endproperty
  property p_excl; !(bus_grant_out && !refreshStrobe_n); endproperty
  property p_holdAns; hold_request_in && !hold |-> ##[1:12] hold; endproperty
  property p_release; bus_grant_out && !hold_request_in |=> !bus_grant_out; endproperty
  property p_ackCause; $rose(holdAck) |-> $past(hold); endproperty
  a_len: assert property (p_len)
    else $error("refresh length");
  a_cmd: assert property (p_cmd)
    else $error("refresh commands");
  a_row: assert property (p_row)
    else $error("refresh row");
  a_grantAck: assert property (p_grantAck)
    else $error("grant without ack");
  a_excl: assert property (p_excl)
    else $error("grant during refresh");
  a_holdAns: assert property (p_holdAns)
    else $error("hold late");
  a_release: assert property (p_release)
    else $error("grant kept");
  a_ackCause: assert property (p_ackCause)
    else $error("ack without hold");
endmodule : rba_link_sva

//--- test_refresh_and_bus_arbitration.sv
// Self-checking bench for the refresh and bus arbitration link.
`timescale 1ns/1ns
module test_refresh_and_bus_arbitration;
  import rba_pkg::*;
  localparam int unsigned PER = 20;
  logic mclk, srst, hiddenMode, cpuDramReq, cpuBusReq, cpuBusy, userReq, userDma8, userDma16;
  logic cpuWait, dramCas_n, dramRas_n, refreshBusy, granted, needSelfRefresh;
  logic sawSelf = 1'b0;
  rba_owner_t owner;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int t0, n, bad;
  rba_link_if link ();
  wire [2:0] watch = {dramCas_n, link.refreshStrobe_n, granted};
  // A short period puts one or two refresh ticks inside each of the three grants of the grant test.
  rba_arbiter #(.PERIOD(PER)) u_rba_arbiter (.mclk, .srst, .link, .hiddenMode, .cpuDramReq,
    .cpuBusReq, .cpuWait, .dramCas_n, .dramRas_n, .owner, .refreshBusy);
  rba_partner u_rba_partner (.mclk, .srst, .link, .cpuBusy, .userReq, .userDma8, .userDma16,
    .granted, .needSelfRefresh);
  rba_link_sva u_rba_link_sva (.mclk, .srst, .hold(link.hold), .holdAck(link.holdAck),
    .hold_request_in(link.hold_request_in), .bus_grant_out(link.bus_grant_out),
    .refreshStrobe_n(link.refreshStrobe_n), .memRead_n(link.memRead_n),
    .refreshRow(link.refreshRow), .refreshRowOe(link.refreshRowOe));
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait; a wait that runs out shows up as a mismatch.
  task automatic waitOn(input int idx, input logic val);
    n = 0;
    while (watch[idx] !== val && n < 80) begin
      @(negedge mclk);
      n++;
    end
    chk(watch[idx], val);
  endtask : waitOn
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (needSelfRefresh === 1'b1) sawSelf <= 1'b1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {srst, hiddenMode, cpuDramReq, cpuBusReq, cpuBusy, userReq, userDma8, userDma16} = 8'h80;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    waitOn(1, 1'b0);
    t0 = cyc;
    chk(link.hold, 1'b1);
    chk(refreshBusy, 1'b1);
    waitOn(2, 1'b0);
    chk(dramRas_n, 1'b1);
    @(negedge mclk);
    chk(dramRas_n, 1'b0);
    waitOn(1, 1'b1);
    waitOn(1, 1'b0);
    chk(8'(cyc - t0), 8'(PER));
    $display("normal refresh done");
    waitOn(1, 1'b1);
    hiddenMode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      {cpuBusReq, cpuDramReq} = i ? 2'b10 : 2'b01;
      waitOn(1, 1'b0);
      chk(link.hold, 1'b0);
      chk(cpuWait, 1'b1);
      chk(refreshBusy, 1'b1);
      waitOn(2, 1'b0);
      chk(dramRas_n, 1'b1);
      waitOn(1, 1'b1);
      chk(cpuWait, 1'b0);
    end
    {hiddenMode, cpuBusReq, cpuDramReq} = 3'b000;
    $display("hidden refresh done");
    for (int k = 0; k < 3; k++) begin
      {userDma8, userDma16, cpuBusy, userReq} = {k == 0, k == 1, k == 0, 1'b1};
      repeat (6) @(negedge mclk);
      if (k == 0) chk(granted, 1'b0);
      cpuBusy = 1'b0;
      waitOn(0, 1'b1);
      chk(link.hold, 1'b1);
      bad = 0;
      repeat (30) begin
        @(negedge mclk);
        bad += (link.refreshStrobe_n !== 1'b1);
      end
      chk(8'(bad), 8'h00);
      chk(8'(owner), k == 0 ? 8'h01 : k == 1 ? 8'h02 : 8'h03);
      userReq = 1'b0;
      if (k < 2) begin
        waitOn(1, 1'b0);
        chk(8'(n < 5), 8'h01);
        waitOn(1, 1'b1);
      end
    end
    chk(sawSelf, 1'b1);
    $display("grant test done");
    waitOn(1, 1'b0);
    {userDma8, userDma16, userReq} = 3'b011;
    @(negedge mclk);
    chk(granted, 1'b0);
    waitOn(0, 1'b1);
    chk(link.refreshStrobe_n, 1'b1);
    userReq = 1'b0;
    waitOn(0, 1'b0);
    $display("order test done");
    test_done();
  end
endmodule : test_refresh_and_bus_arbitration
